/* File: radio_cfg_cfg.svh */
// Register numbers, reset values, ranges and thresholds of the config bank
`ifndef RADIO_CFG_CFG_SVH
`define RADIO_CFG_CFG_SVH

// ********************************************
// Register numbers
// ********************************************
`define REG_NODE_ROLE 8'h65
`define REG_SERIAL_BAUD 8'h66
`define REG_AIR_RATE 8'h67
`define REG_NETWORK_ID 8'h68
`define REG_UNIT_ADDRESS 8'h69
`define REG_TX_POWER 8'h6C
`define REG_SERIAL_FORMAT 8'h6E
`define REG_RETX_LIMIT 8'h71
`define REG_REPEATER_POS 8'h72
`define REG_SYNC_ADDRESS 8'h76
`define REG_UP_STRENGTH 8'h7B
`define REG_DOWN_STRENGTH 8'h7C
`define REG_TOPOLOGY 8'h85

// ********************************************
// Reset values
// ********************************************
`define RST_NODE_ROLE 8'h00
`define RST_SERIAL_BAUD 8'h07
`define RST_AIR_RATE 8'h00
`define RST_NETWORK_ID 32'h499602D2
`define RST_UNIT_ADDRESS 16'h0000
`define RST_TX_POWER 8'h1E
`define RST_SERIAL_FORMAT 8'h01
`define RST_RETX_LIMIT 8'h03
`define RST_REPEATER_POS 8'h01
`define RST_SYNC_ADDRESS 16'h0000
`define RST_TOPOLOGY 8'h00

// ********************************************
// Code sets and ranges
// ********************************************
`define ROLE_MASTER 8'h00
`define ROLE_REPEATER 8'h01
`define ROLE_SLAVE 8'h02
`define TOPO_P2MP 8'h00
`define TOPO_P2P 8'h01
`define TOPO_MESH 8'h02
`define BAUD_LAST_LOW 8'h09
`define BAUD_460800 8'h0F
`define BAUD_921600 8'h10
`define AIR_RATE_MAX 8'h04
`define TX_POWER_MIN 8'h14
`define TX_POWER_MAX 8'h1E
`define FORMAT_8N1 8'h01
`define REPEATER_POS_MIN 8'h01
`define REPEATER_POS_MAX 8'hFE

// ********************************************
// Signal strength (dBm, signed 16 bit)
// ********************************************
`define STRENGTH_FLOOR 16'hFF01
`define STRENGTH_CEIL 16'h0000
`define LEVEL1_DBM 16'hFF9C
`define LEVEL2_DBM 16'hFFAB
`define LEVEL3_DBM 16'hFFBA

`endif

/* File: radio_cfg_pkg.sv */
// Types shared by the radio configuration register bank
package radio_cfg_pkg;

  typedef enum logic [2:0] {
    CMD_QUERY = 3'h1,
    CMD_ASSIGN = 3'h2,
    CMD_SAVE = 3'h4
  } cmd_op_t;

  typedef struct packed {
    cmd_op_t op;
    logic [7:0] reg_num;
    logic [31:0] value;
  } cmd_t;

  typedef struct packed {
    logic ok;
    logic [31:0] data;
  } resp_t;

  typedef struct packed {
    logic [7:0] node_role;
    logic [7:0] serial_baud_code;
    logic [7:0] air_rate_code;
    logic [31:0] network_identifier;
    logic [15:0] unit_address;
    logic [7:0] transmit_power_code;
    logic [7:0] serial_format_code;
    logic [7:0] retransmission_limit;
    logic [7:0] repeater_position;
    logic [15:0] sync_address;
    logic [7:0] topology_type;
  } cfg_t;

endpackage : radio_cfg_pkg

/* File: radio_cfg_regs.sv */
// Configuration and status register bank of a frequency-hopping radio node
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_cfg.svh"

module radio_cfg_regs
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Decoded command port
  input wire logic i_config_mode,
  input wire logic i_cmd_valid,
  input wire radio_cfg_pkg::cmd_t i_cmd,
  output logic o_resp_valid,
  output radio_cfg_pkg::resp_t o_resp,
  // Measured signal strength from the radio
  input wire logic i_strength_valid,
  input wire logic [15:0] i_up_strength,
  input wire logic [15:0] i_down_strength,
  // Received frame network id check
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_network_id,
  output logic o_rx_accept,
  // Committed configuration and derived controls
  output radio_cfg_pkg::cfg_t o_active,
  output logic [19:0] o_baud_divisor,
  output logic [8:0] o_max_transmissions,
  output logic o_sync_source,
  output logic o_auto_unit_address,
  output logic o_auto_sync_address,
  output logic [7:0] o_repeater_position,
  output logic o_broadcast_enable,
  output logic o_forward_enable,
  output logic o_accept_repeater,
  // Level indicator pins
  output logic o_signal_level_pin_1,
  output logic o_signal_level_pin_2,
  output logic o_signal_level_pin_3
);

  localparam int CLK_HZ = 100_000_000;

  // ********************************************
  // Baud rate table
  // ********************************************
  function automatic logic [19:0] baud_rate(input logic [7:0] code);
    case (code)
      8'h00: baud_rate = 20'd230400;
      8'h01: baud_rate = 20'd115200;
      8'h02: baud_rate = 20'd57600;
      8'h03: baud_rate = 20'd38400;
      8'h04: baud_rate = 20'd28800;
      8'h05: baud_rate = 20'd19200;
      8'h06: baud_rate = 20'd14400;
      8'h07: baud_rate = 20'd9600;
      8'h08: baud_rate = 20'd7200;
      8'h09: baud_rate = 20'd4800;
      8'h0F: baud_rate = 20'd460800;
      8'h10: baud_rate = 20'd921600;
      default: baud_rate = 20'd9600;
    endcase
  endfunction : baud_rate

  // ********************************************
  // Command acceptance
  // ********************************************
  radio_cfg_pkg::cfg_t shadow;
  logic take;
  logic known;
  logic accept;
  logic do_write;
  logic [15:0] up_strength;
  logic [15:0] down_strength;
  logic [31:0] read_data;

  // Commands outside configuration mode are dropped silently
  assign take = i_cmd_valid && i_config_mode;

  radio_value_check u_check
  (
    .i_reg_num(i_cmd.reg_num),
    .i_value(i_cmd.value),
    .o_known(known),
    .o_accept(accept)
  );

  assign do_write = take && i_cmd.op == radio_cfg_pkg::CMD_ASSIGN &&
      accept;

  // ********************************************
  // Pending parameter table
  // ********************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      shadow.node_role <= `RST_NODE_ROLE;
      shadow.serial_baud_code <= `RST_SERIAL_BAUD;
      shadow.air_rate_code <= `RST_AIR_RATE;
      shadow.network_identifier <= `RST_NETWORK_ID;
      shadow.unit_address <= `RST_UNIT_ADDRESS;
      shadow.transmit_power_code <= `RST_TX_POWER;
      shadow.serial_format_code <= `RST_SERIAL_FORMAT;
      shadow.retransmission_limit <= `RST_RETX_LIMIT;
      shadow.repeater_position <= `RST_REPEATER_POS;
      shadow.sync_address <= `RST_SYNC_ADDRESS;
      shadow.topology_type <= `RST_TOPOLOGY;
    end
    else if (do_write)
    begin
      case (i_cmd.reg_num)
        `REG_NODE_ROLE: shadow.node_role <= i_cmd.value[7:0];
        `REG_SERIAL_BAUD: shadow.serial_baud_code <= i_cmd.value[7:0];
        `REG_AIR_RATE: shadow.air_rate_code <= i_cmd.value[7:0];
        `REG_NETWORK_ID: shadow.network_identifier <= i_cmd.value;
        `REG_UNIT_ADDRESS: shadow.unit_address <= i_cmd.value[15:0];
        `REG_TX_POWER: shadow.transmit_power_code <= i_cmd.value[7:0];
        `REG_SERIAL_FORMAT:
          shadow.serial_format_code <= i_cmd.value[7:0];
        `REG_RETX_LIMIT:
          shadow.retransmission_limit <= i_cmd.value[7:0];
        `REG_REPEATER_POS: shadow.repeater_position <= i_cmd.value[7:0];
        `REG_SYNC_ADDRESS: shadow.sync_address <= i_cmd.value[15:0];
        `REG_TOPOLOGY: shadow.topology_type <= i_cmd.value[7:0];
        default: shadow <= shadow;
      endcase
    end
  end

  // ********************************************
  // Committed table
  // ********************************************
  // Live radio logic only sees saved values, so half-typed edits are harmless
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_active <= {`RST_NODE_ROLE, `RST_SERIAL_BAUD, `RST_AIR_RATE,
          `RST_NETWORK_ID, `RST_UNIT_ADDRESS, `RST_TX_POWER,
          `RST_SERIAL_FORMAT, `RST_RETX_LIMIT, `RST_REPEATER_POS,
          `RST_SYNC_ADDRESS, `RST_TOPOLOGY};
    end
    else if (take && i_cmd.op == radio_cfg_pkg::CMD_SAVE)
    begin
      o_active <= shadow;
    end
  end

  // ********************************************
  // Read path and answer
  // ********************************************
  always_comb
  begin
    read_data = 32'h00000000;
    case (i_cmd.reg_num)
      `REG_NODE_ROLE: read_data[7:0] = shadow.node_role;
      `REG_SERIAL_BAUD: read_data[7:0] = shadow.serial_baud_code;
      `REG_AIR_RATE: read_data[7:0] = shadow.air_rate_code;
      `REG_NETWORK_ID: read_data = shadow.network_identifier;
      `REG_UNIT_ADDRESS: read_data[15:0] = shadow.unit_address;
      `REG_TX_POWER: read_data[7:0] = shadow.transmit_power_code;
      `REG_SERIAL_FORMAT: read_data[7:0] = shadow.serial_format_code;
      `REG_RETX_LIMIT: read_data[7:0] = shadow.retransmission_limit;
      `REG_REPEATER_POS: read_data[7:0] = shadow.repeater_position;
      `REG_SYNC_ADDRESS: read_data[15:0] = shadow.sync_address;
      `REG_UP_STRENGTH: read_data = {{16{up_strength[15]}}, up_strength};
      `REG_DOWN_STRENGTH:
        read_data = {{16{down_strength[15]}}, down_strength};
      `REG_TOPOLOGY: read_data[7:0] = shadow.topology_type;
      default: read_data = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_resp_valid <= 1'b0;
      o_resp <= '0;
    end
    else
    begin
      o_resp_valid <= take;
      case (i_cmd.op)
        radio_cfg_pkg::CMD_QUERY: o_resp <= {known, read_data};
        radio_cfg_pkg::CMD_ASSIGN: o_resp <= {accept, 32'h00000000};
        radio_cfg_pkg::CMD_SAVE: o_resp <= {1'b1, 32'h00000000};
        default: o_resp <= {1'b0, 32'h00000000};
      endcase
    end
  end

  // ********************************************
  // Signal strength capture
  // ********************************************
  function automatic logic [15:0] clamp(input logic [15:0] v);
    if ($signed(v) < $signed(`STRENGTH_FLOOR))
      clamp = `STRENGTH_FLOOR;
    else if ($signed(v) > $signed(`STRENGTH_CEIL))
      clamp = `STRENGTH_CEIL;
    else
      clamp = v;
  endfunction : clamp

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      up_strength <= `STRENGTH_FLOOR;
      down_strength <= `STRENGTH_FLOOR;
    end
    else if (i_strength_valid)
    begin
      up_strength <= clamp(i_up_strength);
      down_strength <= clamp(i_down_strength);
    end
  end

  // Pins follow the link this role listens to most
  logic [15:0] shown;
  assign shown = (o_active.node_role == `ROLE_MASTER) ?
      down_strength : up_strength;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_signal_level_pin_1 <= 1'b0;
      o_signal_level_pin_2 <= 1'b0;
      o_signal_level_pin_3 <= 1'b0;
    end
    else
    begin
      o_signal_level_pin_1 <= $signed(shown) >= $signed(`LEVEL1_DBM);
      o_signal_level_pin_2 <= $signed(shown) >= $signed(`LEVEL2_DBM);
      o_signal_level_pin_3 <= $signed(shown) >= $signed(`LEVEL3_DBM);
    end
  end

  // ********************************************
  // Derived controls from committed table
  // ********************************************
  logic p2p_auto;
  assign p2p_auto = o_active.topology_type == `TOPO_P2P &&
      o_active.unit_address == 16'h0000;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_baud_divisor <= 20'(CLK_HZ / 9600);
      o_max_transmissions <= 9'h004;
      o_sync_source <= 1'b1;
      o_auto_unit_address <= 1'b0;
      o_auto_sync_address <= 1'b0;
      o_repeater_position <= 8'h00;
      // Reset table is a multipoint master, so broadcast and repeaters on
      o_broadcast_enable <= 1'b1;
      o_forward_enable <= 1'b0;
      o_accept_repeater <= 1'b1;
    end
    else
    begin
      // leaves the host to follow this divisor change
      o_baud_divisor <= 20'(CLK_HZ / baud_rate(o_active.serial_baud_code));
      o_max_transmissions <= {1'b0, o_active.retransmission_limit} +
          9'h001;
      o_sync_source <= o_active.node_role == `ROLE_MASTER;
      o_auto_unit_address <= p2p_auto;
      o_auto_sync_address <= p2p_auto;
      o_repeater_position <= (p2p_auto &&
          o_active.node_role == `ROLE_REPEATER) ?
          o_active.repeater_position : 8'h00;
      o_broadcast_enable <= o_active.topology_type == `TOPO_P2MP &&
          o_active.node_role == `ROLE_MASTER;
      o_forward_enable <= o_active.topology_type != `TOPO_MESH &&
          o_active.node_role == `ROLE_REPEATER;
      o_accept_repeater <= o_active.topology_type != `TOPO_MESH;
    end
  end

  // ********************************************
  // Network id filter
  // ********************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      o_rx_accept <= 1'b0;
    else
      o_rx_accept <= i_rx_valid &&
          i_rx_network_id == o_active.network_identifier;
  end

endmodule : radio_cfg_regs
`default_nettype wire

/* File: radio_cfg_regs_chk.sv */
// Assertion checker of the radio config register bank
`timescale 1ns/10ps
`default_nettype none
module radio_cfg_regs_chk
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Command port
  input wire logic i_config_mode,
  input wire logic i_cmd_valid,
  input wire radio_cfg_pkg::cmd_t i_cmd,
  input wire logic o_resp_valid,
  input wire radio_cfg_pkg::resp_t o_resp,
  // Network id check
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_network_id,
  input wire logic o_rx_accept,
  // Committed table and derived controls
  input wire radio_cfg_pkg::cfg_t o_active,
  input wire logic [8:0] o_max_transmissions,
  input wire logic o_sync_source,
  input wire logic o_accept_repeater,
  input wire logic o_signal_level_pin_1,
  input wire logic o_signal_level_pin_2,
  input wire logic o_signal_level_pin_3
);
  // ****************************************
  // Helpers
  // ****************************************
  logic rx_hit;
  assign rx_hit = i_rx_valid &&
    (i_rx_network_id == o_active.network_identifier);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  sequence s_taken;
    i_cmd_valid && i_config_mode;
  endsequence
  sequence s_strength_write;
    s_taken ##0 (i_cmd.op == radio_cfg_pkg::CMD_ASSIGN &&
      i_cmd.reg_num inside {8'h7B, 8'h7C});
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_resp_after_taken: assert property (s_taken |=> o_resp_valid)
    else $error("no answer one cycle after a taken command");
  a_resp_no_cause: assert property (
    !(i_cmd_valid && i_config_mode) |=> !o_resp_valid)
    else $error("answer without a taken command");
  a_strength_read_only: assert property (
    s_strength_write |=> o_resp_valid && !o_resp.ok)
    else $error("strength write accepted");
  a_power_in_range: assert property (
    o_active.transmit_power_code inside {[8'h14:8'h1E]})
    else $error("committed power code out of range");
  a_baud_code_set: assert property (
    o_active.serial_baud_code inside {[8'h00:8'h09], 8'h0F, 8'h10})
    else $error("committed baud code not in set");
  a_format_fixed: assert property (o_active.serial_format_code == 8'h01)
    else $error("committed format not 8N1");
  a_max_tx_count: assert property (
    o_max_transmissions ==
    {1'b0, $past(o_active.retransmission_limit)} + 9'h001)
    else $error("transmission count not limit plus one");
  a_sync_by_master: assert property (
    o_sync_source == ($past(o_active.node_role) == 8'h00))
    else $error("sync source does not follow master role");
  a_mesh_no_repeat: assert property (
    o_accept_repeater == ($past(o_active.topology_type) != 8'h02))
    else $error("repeater acceptance wrong for topology");
  a_rx_id_match: assert property (o_rx_accept == $past(rx_hit))
    else $error("frame accept does not match network id");
  a_level_pins_order: assert property (
    o_signal_level_pin_3 |-> o_signal_level_pin_2 && o_signal_level_pin_1)
    else $error("level pins out of order");
endmodule : radio_cfg_regs_chk
bind radio_cfg_regs radio_cfg_regs_chk u_radio_cfg_regs_chk (.i_sys_clk,
  .i_srst,
  .i_config_mode, .i_cmd_valid, .i_cmd, .o_resp_valid, .o_resp, .i_rx_valid,
  .i_rx_network_id, .o_rx_accept, .o_active, .o_max_transmissions,
  .o_sync_source, .o_accept_repeater, .o_signal_level_pin_1,
  .o_signal_level_pin_2, .o_signal_level_pin_3);
`default_nettype wire

/* File: radio_cfg_regs_tb.sv */
// Testbench of the radio config register bank
`timescale 1ns/10ps
`default_nettype none
module radio_cfg_regs_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk, srst, cfg_mode, cmd_valid, resp_valid, str_valid, rx_valid;
  logic rx_accept, sync_src, auto_unit, auto_sync, bcast, fwd, acc_rep, got;
  logic [15:0] up_str, down_str;
  logic [31:0] rx_id;
  logic [19:0] baud_div;
  logic [8:0] max_tx;
  logic [7:0] rep_pos;
  logic [2:0] pin;
  radio_cfg_pkg::cmd_t cmd;
  radio_cfg_pkg::resp_t resp, rsp;
  radio_cfg_pkg::cfg_t act;
  int errors, compares, cycles;
  logic [7:0] def_reg[13] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6C, 8'h6E,
    8'h71, 8'h72, 8'h76, 8'h7B, 8'h7C, 8'h85};
  logic [31:0] def_val[13] = '{32'h0, 32'h7, 32'h0, 32'h499602D2, 32'h0, 32'h1E,
    32'h1, 32'h3, 32'h1, 32'h0, 32'hFFFFFF01, 32'hFFFFFF01, 32'h0};
  logic [7:0] bad_reg[8] = '{8'h6E, 8'h6E, 8'h72, 8'h72, 8'h71, 8'h7B, 8'h7C, 8'h69};
  logic [31:0] bad_val[8] = '{32'h0, 32'h2, 32'h0, 32'hFF, 32'h100, 32'h0, 32'h0,
    32'h10000};
  radio_cfg_regs u_radio_cfg_regs (.i_sys_clk(clk), .i_srst(srst),
    .i_config_mode(cfg_mode), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_resp_valid(resp_valid), .o_resp(resp), .i_strength_valid(str_valid),
    .i_up_strength(up_str), .i_down_strength(down_str), .i_rx_valid(rx_valid),
    .i_rx_network_id(rx_id), .o_rx_accept(rx_accept), .o_active(act),
    .o_baud_divisor(baud_div), .o_max_transmissions(max_tx),
    .o_sync_source(sync_src), .o_auto_unit_address(auto_unit),
    .o_auto_sync_address(auto_sync), .o_repeater_position(rep_pos),
    .o_broadcast_enable(bcast), .o_forward_enable(fwd),
    .o_accept_repeater(acc_rep), .o_signal_level_pin_1(pin[0]),
    .o_signal_level_pin_2(pin[1]), .o_signal_level_pin_3(pin[2]));
  radio_host_model u_radio_host_model (.i_sys_clk(clk), .o_cmd_valid(cmd_valid),
    .o_cmd(cmd), .i_resp_valid(resp_valid), .i_resp(resp));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] n, input logic [31:0] v, input logic ok);
    u_radio_host_model.issue(radio_cfg_pkg::CMD_ASSIGN, n, v, got, rsp);
    check({30'h0, got, rsp.ok}, {30'h0, 1'b1, ok});
  endtask : wr
  task automatic rd(input logic [7:0] n, input logic [31:0] v);
    u_radio_host_model.issue(radio_cfg_pkg::CMD_QUERY, n, 32'h0, got, rsp);
    check({31'h0, got}, 32'h1);
    check(rsp.data, v);
  endtask : rd
  task automatic save;
    u_radio_host_model.issue(radio_cfg_pkg::CMD_SAVE, 8'h0, 32'h0, got, rsp);
    check({30'h0, got, rsp.ok}, 32'h3);
    repeat (2) @(negedge clk);
  endtask : save
  task automatic strength(input logic [15:0] up, input logic [15:0] down);
    @(negedge clk);
    str_valid = 1'b1;
    up_str = up;
    down_str = down;
    @(negedge clk);
    str_valid = 1'b0;
    repeat (2) @(negedge clk);
  endtask : strength
  // ****************************************
  // Clock, timeout and tests
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    srst = 1'b1;
    cfg_mode = 1'b1;
    str_valid = 1'b0;
    up_str = 16'h0;
    down_str = 16'h0;
    rx_valid = 1'b0;
    rx_id = 32'h0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    for (int k = 0; k < 13; k++) rd(def_reg[k], def_val[k]);
    check({12'h0, baud_div}, 32'h28B0);
    check({23'h0, max_tx}, 32'h4);
    for (int k = 0; k < 8; k++) wr(bad_reg[k], bad_val[k], 1'b0);
    for (int k = 0; k < 13; k++) rd(def_reg[k], def_val[k]);
    for (int v = 0; v < 4; v++) wr(8'h65, v, v < 3);
    for (int v = 0; v < 18; v++)
      wr(8'h66, v, v < 10 || v == 15 || v == 16);
    for (int v = 0; v < 6; v++) wr(8'h67, v, v < 5);
    for (int v = 0; v < 4; v++) wr(8'h85, v, v < 3);
    for (int v = 19; v < 32; v++) wr(8'h6C, v, v > 19 && v < 31);
    rd(8'h66, 32'h10);
    cfg_mode = 1'b0;
    u_radio_host_model.issue(radio_cfg_pkg::CMD_QUERY, 8'h65, 32'h0, got, rsp);
    check({31'h0, got}, 32'h0);
    cfg_mode = 1'b1;
    wr(8'h6C, 32'h19, 1'b1);
    rd(8'h6C, 32'h19);
    check({24'h0, act.transmit_power_code}, 32'h1E);
    save();
    check({24'h0, act.transmit_power_code}, 32'h19);
    check({12'h0, baud_div}, 32'h6C);
    wr(8'h65, 32'h1, 1'b1);
    wr(8'h85, 32'h1, 1'b1);
    wr(8'h72, 32'h5, 1'b1);
    wr(8'h71, 32'hFF, 1'b1);
    wr(8'h68, 32'hFFFFFFFF, 1'b1);
    save();
    check({24'h0, rep_pos}, 32'h5);
    check({29'h0, auto_unit, auto_sync, sync_src}, 32'h6);
    check({23'h0, max_tx}, 32'h100);
    check({30'h0, fwd, acc_rep}, 32'h3);
    wr(8'h69, 32'h7, 1'b1);
    save();
    check({24'h0, rep_pos}, 32'h0);
    check({30'h0, auto_unit, auto_sync}, 32'h0);
    wr(8'h85, 32'h2, 1'b1);
    save();
    check({30'h0, fwd, acc_rep}, 32'h0);
    wr(8'h65, 32'h0, 1'b1);
    wr(8'h85, 32'h0, 1'b1);
    save();
    check({30'h0, bcast, sync_src}, 32'h3);
    strength(16'hFFCE, 16'hFF88);
    rd(8'h7B, 32'hFFFFFFCE);
    rd(8'h7C, 32'hFFFFFF88);
    check({29'h0, pin}, 32'h0);
    wr(8'h65, 32'h1, 1'b1);
    save();
    check({29'h0, pin}, 32'h7);
    strength(16'hFFA6, 16'hFED4);
    check({29'h0, pin}, 32'h1);
    rd(8'h7C, 32'hFFFFFF01);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_id = 32'hFFFFFFFF;
    @(negedge clk);
    rx_id = 32'h499602D2;
    check({31'h0, rx_accept}, 32'h1);
    @(negedge clk);
    rx_valid = 1'b0;
    check({31'h0, rx_accept}, 32'h0);
    conclude();
  end
endmodule : radio_cfg_regs_tb
`default_nettype wire

/* File: radio_host_model.sv */
// Host model issuing decoded commands to the config bank
`timescale 1ns/10ps
`default_nettype none
module radio_host_model
(
  // Clock
  input wire logic i_sys_clk,
  // Command port towards the bank
  output logic o_cmd_valid,
  output radio_cfg_pkg::cmd_t o_cmd,
  input wire logic i_resp_valid,
  input wire radio_cfg_pkg::resp_t i_resp
);
  // ****************************************
  // Command issue
  // ****************************************
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end
  task automatic issue(input radio_cfg_pkg::cmd_op_t op, input logic [7:0] num,
    input logic [31:0] val, output logic got, output radio_cfg_pkg::resp_t resp);
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b1;
    o_cmd = '{op, num, val};
    @(negedge i_sys_clk);
    o_cmd_valid = 1'b0;
    // Released bus carries no stale command
    o_cmd = radio_cfg_pkg::cmd_t'(~o_cmd);
    got = i_resp_valid;
    resp = i_resp;
  endtask : issue
endmodule : radio_host_model
`default_nettype wire

/* File: radio_value_check.sv */
// Range and code-set check of a value written to one register
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_cfg.svh"

module radio_value_check
(
  // Write under test
  input wire logic [7:0] i_reg_num,
  input wire logic [31:0] i_value,
  // Verdict
  output logic o_known,
  output logic o_accept
);

  logic hi8_zero;
  logic hi16_zero;
  logic [7:0] v8;

  assign hi8_zero = (i_value[31:8] == 24'h000000);
  assign hi16_zero = (i_value[31:16] == 16'h0000);
  assign v8 = i_value[7:0];

  always_comb
  begin
    o_known = 1'b1;
    o_accept = 1'b0;
    case (i_reg_num)
      `REG_NODE_ROLE: o_accept = hi8_zero && v8 <= `ROLE_SLAVE;
      `REG_SERIAL_BAUD: o_accept = hi8_zero && (v8 <= `BAUD_LAST_LOW ||
          v8 == `BAUD_460800 || v8 == `BAUD_921600);
      `REG_AIR_RATE: o_accept = hi8_zero && v8 <= `AIR_RATE_MAX;
      `REG_NETWORK_ID: o_accept = 1'b1;
      `REG_UNIT_ADDRESS: o_accept = hi16_zero;
      `REG_TX_POWER: o_accept = hi8_zero && v8 >= `TX_POWER_MIN &&
          v8 <= `TX_POWER_MAX;
      `REG_SERIAL_FORMAT: o_accept = hi8_zero && v8 == `FORMAT_8N1;
      `REG_RETX_LIMIT: o_accept = hi8_zero;
      `REG_REPEATER_POS: o_accept = hi8_zero &&
          v8 >= `REPEATER_POS_MIN && v8 <= `REPEATER_POS_MAX;
      `REG_SYNC_ADDRESS: o_accept = hi16_zero;
      `REG_TOPOLOGY: o_accept = hi8_zero && v8 <= `TOPO_MESH;
      // Read-only strength registers are known but never writable
      `REG_UP_STRENGTH: o_accept = 1'b0;
      `REG_DOWN_STRENGTH: o_accept = 1'b0;
      default: o_known = 1'b0;
    endcase
  end

endmodule : radio_value_check
`default_nettype wire
